// ===== pkg/chgseq_pkg.sv
// constants and types for the charge sequencer
package chgseq_pkg;
    // oscillator period with the default timing capacitor
    localparam int TOSC_NS          = 3000000;
    localparam int MCLK_NS          = 20;
    // oscillator ticks derived from mclk (longest time, rounded down)
    localparam int OSC_CYC          = TOSC_NS / MCLK_NS;
    localparam int STEP_MS          = 500;
    localparam int SETTLE_MS        = 500;
    localparam int OPEN_MS          = 70;
    // ticks per period, least time rounds up
    localparam int STEP_TICKS       = (STEP_MS * 1000 + TOSC_NS / 1000 - 1) / (TOSC_NS / 1000);
    localparam int SETTLE_TICKS     = (SETTLE_MS * 1000 + TOSC_NS / 1000 - 1) / (TOSC_NS / 1000);
    localparam int OPEN_TICKS       = (OPEN_MS * 1000 + TOSC_NS / 1000 - 1) / (TOSC_NS / 1000);
    localparam int SHORT_TICKS      = 384;
    localparam int TRICKLE_MIN      = 15;
    localparam int EOC_TICKS        = 3;
    localparam int TIMEOUT_TICKS    = 14400;
    localparam int FLASH_TICKS      = 100;
    localparam int CNT_W            = 16;

    typedef enum logic [3:0] {
        CS_PLUG_RED, CS_PLUG_GRN, CS_PLUG_YEL, CS_IDLE, CS_SETTLE, CS_OPEN_CHK,
        CS_SHORT_CHK, CS_TRICKLE, CS_FAST, CS_DONE, CS_FAULT, CS_HALT
    } chgseq_state_e;
endpackage

// ===== hdl/chgseq_top.sv
// charge phase sequencer with plug-in indication, faults and recharge loop
`timescale 1ns/1ps
// Notes on behaviour
// - plug-in indication red, green, yellow, off
// - each indication step lasts 500ms
// - idle, charging off until enable low
// - 500ms settling delay after enable
// - open battery: no charge, leds off
// - check short circuit before charging
// - below 1V after 384 ticks: fault
// - trickle starts with red indicator on
// - trickle at tenth current until fast threshold
// - no 2.8V in timeout/8: fault
// - constant current then constant voltage
// - end-of-charge current: red to green
// - end of charge qualified 3 ticks in a row
// - timeout expiry also ends charge
// - recharge below threshold until full again
// - recharge loop repeats until enable removed
// - no charging with ambient out of range
// - higher ambient limit while charging
// - current foldback at 100 degrees die
module chgseq_top #(
    parameter int TIMEOUT = chgseq_pkg::TIMEOUT_TICKS,
    parameter int OSC_DIV = chgseq_pkg::OSC_CYC
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic enable_n,
    input  wire logic vsen_open,
    input  wire logic above_1v,
    input  wire logic above_fast_min,
    input  wire logic at_charge_voltage,
    input  wire logic below_eoc_current,
    input  wire logic above_recharge,
    input  wire logic temp_below_low,
    input  wire logic temp_above_chg_hi,
    input  wire logic temp_above_idle_hi,
    input  wire logic die_hot,
    output logic      charge_on_q,
    output logic      trickle_q,
    output logic      cv_mode_q,
    output logic      foldback_q,
    output logic      charging_q,
    output logic      red_led_on_q,
    output logic      green_led_drive_q
);
    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NIN = 11;
    logic [NIN-1:0] s1_q, s1_d, s2_q, s2_d;
    always_comb begin
        s1_d = {enable_n, vsen_open, above_1v, above_fast_min, at_charge_voltage,
                below_eoc_current, above_recharge, temp_below_low, temp_above_chg_hi,
                temp_above_idle_hi, die_hot};
        s2_d = s1_q;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= '1;
            s2_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end
    logic en_n_s, open_s, v1_s, fast_charge_min_voltage_s, vch_s, eoc_s, rch_s, tlo_s, thc_s, thi_s, hot_s;
    assign {en_n_s, open_s, v1_s, fast_charge_min_voltage_s, vch_s, eoc_s, rch_s, tlo_s, thc_s, thi_s,
            hot_s} = s2_q;

    // ****************************************
    // oscillator tick
    // ****************************************
    logic [23:0] div_q, div_d;
    logic        tick;
    always_comb begin
        tick  = (div_q == 24'(OSC_DIV - 1));
        div_d = tick ? 24'h000000 : div_q + 24'h000001;
    end
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) div_q <= 24'h000000;
        else       div_q <= div_d;
    end

    // ****************************************
    // sequencer
    // ****************************************
    chgseq_pkg::chgseq_state_e st_q, st_d;
    logic [chgseq_pkg::CNT_W-1:0] cnt_q, cnt_d, tot_q, tot_d;
    logic [2:0] eoc_q, eoc_d;
    logic       flash_q, flash_d, eocled_q, eocled_d;
    logic       chg_d, trk_d, cv_d, fold_d, charging_d, red_d, grn_d;
    logic       temp_ok, enter;

    always_comb begin
        st_d     = st_q;
        cnt_d    = tick ? cnt_q + 16'h0001 : cnt_q;
        tot_d    = tot_q;
        eoc_d    = eoc_q;
        flash_d  = flash_q;
        eocled_d = eocled_q;
        temp_ok  = !tlo_s && (charging_q ? !thc_s : !thi_s);
        unique case (st_q)
            chgseq_pkg::CS_PLUG_RED:
                if (cnt_q == 16'(chgseq_pkg::STEP_TICKS)) st_d = chgseq_pkg::CS_PLUG_GRN;
            chgseq_pkg::CS_PLUG_GRN:
                if (cnt_q == 16'(chgseq_pkg::STEP_TICKS)) st_d = chgseq_pkg::CS_PLUG_YEL;
            chgseq_pkg::CS_PLUG_YEL:
                if (cnt_q == 16'(chgseq_pkg::STEP_TICKS)) st_d = chgseq_pkg::CS_IDLE;
            chgseq_pkg::CS_IDLE:
                if (!en_n_s && temp_ok) st_d = chgseq_pkg::CS_SETTLE;
            chgseq_pkg::CS_SETTLE:
                if (cnt_q == 16'(chgseq_pkg::SETTLE_TICKS)) st_d = chgseq_pkg::CS_OPEN_CHK;
            chgseq_pkg::CS_OPEN_CHK:
                if (cnt_q == 16'(chgseq_pkg::OPEN_TICKS))
                    st_d = open_s ? chgseq_pkg::CS_HALT : chgseq_pkg::CS_SHORT_CHK;
            chgseq_pkg::CS_SHORT_CHK:
                if (cnt_q == 16'(chgseq_pkg::SHORT_TICKS))
                    st_d = v1_s ? chgseq_pkg::CS_TRICKLE : chgseq_pkg::CS_FAULT;
            chgseq_pkg::CS_TRICKLE:
                if (cnt_q >= 16'(chgseq_pkg::TRICKLE_MIN) && fast_charge_min_voltage_s)
                    st_d = chgseq_pkg::CS_FAST;
                else if (tot_q >= 16'(TIMEOUT / 8))
                    st_d = chgseq_pkg::CS_FAULT;
            chgseq_pkg::CS_FAST: begin
                if (tick) eoc_d = (eoc_s && rch_s) ? eoc_q + 3'h1 : 3'h0;
                if (eoc_q == 3'(chgseq_pkg::EOC_TICKS) || tot_q >= 16'(TIMEOUT)) begin
                    st_d     = chgseq_pkg::CS_DONE;
                    eocled_d = 1'b1;
                end
            end
            chgseq_pkg::CS_DONE:
                if (!rch_s && temp_ok) begin
                    st_d  = chgseq_pkg::CS_FAST;
                    tot_d = 16'h0000;
                end
            chgseq_pkg::CS_FAULT:
                // count is cleared in the same cycle, so no tick gating here
                if (cnt_q == 16'(chgseq_pkg::FLASH_TICKS)) flash_d = !flash_q;
            chgseq_pkg::CS_HALT: ;
        endcase
        // ambient out of range pauses charge
        if ((st_q == chgseq_pkg::CS_TRICKLE || st_q == chgseq_pkg::CS_FAST) && !temp_ok)
            st_d = chgseq_pkg::CS_IDLE;
        if (en_n_s && st_q > chgseq_pkg::CS_IDLE) st_d = chgseq_pkg::CS_IDLE;
        enter = (st_d != st_q);
        if (enter || (st_q == chgseq_pkg::CS_FAULT && cnt_q == 16'(chgseq_pkg::FLASH_TICKS)))
            cnt_d = 16'h0000;
        if (enter) eoc_d = 3'h0;
        if (st_d == chgseq_pkg::CS_IDLE) begin
            eocled_d = 1'b0;
            flash_d  = 1'b0;
        end
        if (st_d == chgseq_pkg::CS_TRICKLE && st_q != chgseq_pkg::CS_TRICKLE) tot_d = 16'h0000;
        else if (tick && (st_q == chgseq_pkg::CS_TRICKLE || st_q == chgseq_pkg::CS_FAST))
            tot_d = tot_q + 16'h0001;
        // cc then cv at full voltage
        chg_d      = st_d inside {chgseq_pkg::CS_OPEN_CHK, chgseq_pkg::CS_SHORT_CHK,
                                   chgseq_pkg::CS_TRICKLE, chgseq_pkg::CS_FAST};
        trk_d      = chg_d && st_d != chgseq_pkg::CS_FAST;
        cv_d       = st_d == chgseq_pkg::CS_FAST && vch_s;
        fold_d     = chg_d && hot_s;
        charging_d = st_d == chgseq_pkg::CS_TRICKLE || st_d == chgseq_pkg::CS_FAST;
        red_d      = st_d == chgseq_pkg::CS_PLUG_RED || st_d == chgseq_pkg::CS_PLUG_YEL ||
                     (charging_d && !eocled_d) || (st_d == chgseq_pkg::CS_FAULT && flash_d);
        grn_d      = st_d == chgseq_pkg::CS_PLUG_GRN || st_d == chgseq_pkg::CS_PLUG_YEL ||
                     ((charging_d || st_d == chgseq_pkg::CS_DONE) && eocled_d) ||
                     (st_d == chgseq_pkg::CS_FAULT && flash_d);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q              <= chgseq_pkg::CS_PLUG_RED;
            cnt_q             <= 16'h0000;
            tot_q             <= 16'h0000;
            eoc_q             <= 3'h0;
            flash_q           <= 1'b0;
            eocled_q          <= 1'b0;
            charge_on_q       <= 1'b0;
            trickle_q         <= 1'b0;
            cv_mode_q         <= 1'b0;
            foldback_q        <= 1'b0;
            charging_q        <= 1'b0;
            red_led_on_q      <= 1'b1;
            green_led_drive_q <= 1'b0;
        end else begin
            st_q              <= st_d;
            cnt_q             <= cnt_d;
            tot_q             <= tot_d;
            eoc_q             <= eoc_d;
            flash_q           <= flash_d;
            eocled_q          <= eocled_d;
            charge_on_q       <= chg_d;
            trickle_q         <= trk_d;
            cv_mode_q         <= cv_d;
            foldback_q        <= fold_d;
            charging_q        <= charging_d;
            red_led_on_q      <= red_d;
            green_led_drive_q <= grn_d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_enable_off;
        @(posedge mclk) disable iff (!rstn) en_n_s |-> ##2 !charge_on_q;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("charge on without enable");
    property p_fault_off;
        @(posedge mclk) disable iff (!rstn) st_q == chgseq_pkg::CS_FAULT |=> !charge_on_q;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("charging in fault");
    property p_halt_dark;
        @(posedge mclk) disable iff (!rstn)
            st_q == chgseq_pkg::CS_HALT |=> !red_led_on_q && !green_led_drive_q;
    endproperty
    a_halt_dark: assert property (p_halt_dark) else $error("led lit after open");
    property p_trickle_red;
        @(posedge mclk) disable iff (!rstn)
            st_q == chgseq_pkg::CS_TRICKLE && !eocled_q |-> red_led_on_q && trickle_q;
    endproperty
    a_trickle_red: assert property (p_trickle_red) else $error("trickle without red");
    property p_done_green;
        @(posedge mclk) disable iff (!rstn)
            st_q == chgseq_pkg::CS_DONE |-> green_led_drive_q && !red_led_on_q && !charge_on_q;
    endproperty
    a_done_green: assert property (p_done_green) else $error("eoc indication wrong");
    property p_fold;
        @(posedge mclk) disable iff (!rstn) charge_on_q && $past(hot_s) |-> foldback_q;
    endproperty
    a_fold: assert property (p_fold) else $error("no foldback when hot");
    property p_temp;
        @(posedge mclk) disable iff (!rstn)
            st_q == chgseq_pkg::CS_IDLE && thi_s |=> st_q != chgseq_pkg::CS_SETTLE;
    endproperty
    a_temp: assert property (p_temp) else $error("started while too hot");
    property p_plug;
        @(posedge mclk) disable iff (!rstn)
            st_q == chgseq_pkg::CS_PLUG_GRN |-> green_led_drive_q && !red_led_on_q;
    endproperty
    a_plug: assert property (p_plug) else $error("plug-in green step wrong");
endmodule

// ===== test/chgseq_batt.sv
// battery pack and current-limited adapter model driving the comparator levels
`timescale 1ns/1ps
module chgseq_batt (
    input  wire logic       mclk,
    input  wire logic       inserted,
    input  wire logic [1:0] kind,
    input  wire logic       drain,
    input  wire logic       charging,
    input  wire logic       trickle,
    input  wire logic       charge_on,
    output logic            enable_n,
    output logic            vsen_open,
    output logic            above_1v,
    output logic            above_fast_min,
    output logic            at_charge_voltage,
    output logic            below_eoc_current,
    output logic            above_recharge
);
    // kind: 0 good, 1 loose terminal, 2 shorted, 3 dead cell
    logic [7:0] lvl_q = 8'h00;
    logic       half_q = 1'b0;
    // trickle charges at half rate so the fast threshold needs some ticks
    always @(posedge mclk) begin
        half_q <= ~half_q;
        if (!inserted) lvl_q <= 8'h00;
        else if (drain && lvl_q != 8'h00) lvl_q <= lvl_q - 8'h01;
        else if (charging && lvl_q != 8'hFF && kind != 2'h3 && (!trickle || half_q))
            lvl_q <= lvl_q + 8'h01;
    end
    assign enable_n = ~inserted;
    assign vsen_open = (kind == 2'h1) & charge_on;
    assign above_1v = (kind != 2'h2);
    assign above_fast_min = (lvl_q >= 8'h28);
    assign at_charge_voltage = (lvl_q >= 8'hC8);
    // current tapers to nothing only when the cell is full
    assign below_eoc_current = (lvl_q == 8'hFF);
    assign above_recharge = (lvl_q >= 8'hB4);
endmodule

// ===== test/chgseq_top_tb.sv
// self-checking bench for the charge sequencer
`timescale 1ns/1ps
module chgseq_top_tb;
    localparam int DIV = 4;
    localparam int TOUT = 256;
    localparam int STEP = chgseq_pkg::STEP_TICKS * DIV;
    localparam int SET = chgseq_pkg::SETTLE_TICKS * DIV;
    localparam int OPN = chgseq_pkg::OPEN_TICKS * DIV;
    localparam int SHT = chgseq_pkg::SHORT_TICKS * DIV;
    localparam int FL = 2 * chgseq_pkg::FLASH_TICKS * DIV + 20;
    logic       mclk = 1'b0;
    logic       rstn = 1'b0;
    logic       inserted = 1'b0;
    logic [1:0] kind = 2'h0;
    logic       drain = 1'b0;
    logic [3:0] temp = 4'h0;
    wire        enable_n, vsen_open, above_1v, fast, cv_v, eoc, rech;
    // charge_on, trickle, cv, foldback, charging, red, green
    wire  [6:0] obs;
    int         n_mismatch = 0;
    int         n_checks = 0;
    int         cyc = 0;

    chgseq_top #(.TIMEOUT(TOUT), .OSC_DIV(DIV)) uut (
        .mclk(mclk), .rstn(rstn), .enable_n(enable_n), .vsen_open(vsen_open),
        .above_1v(above_1v), .above_fast_min(fast), .at_charge_voltage(cv_v),
        .below_eoc_current(eoc), .above_recharge(rech), .temp_below_low(temp[3]),
        .temp_above_chg_hi(temp[2]), .temp_above_idle_hi(temp[1]), .die_hot(temp[0]),
        .charge_on_q(obs[6]), .trickle_q(obs[5]), .cv_mode_q(obs[4]),
        .foldback_q(obs[3]), .charging_q(obs[2]), .red_led_on_q(obs[1]),
        .green_led_drive_q(obs[0]));
    chgseq_batt batt (
        .mclk(mclk), .inserted(inserted), .kind(kind), .drain(drain),
        .charging(obs[2]), .trickle(obs[5]), .charge_on(obs[6]), .enable_n(enable_n),
        .vsen_open(vsen_open), .above_1v(above_1v), .above_fast_min(fast),
        .at_charge_voltage(cv_v), .below_eoc_current(eoc), .above_recharge(rech));

    initial begin
        forever #10 mclk = ~mclk;
    end

    task automatic tally_and_finish;
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // bounded wait on one status bit, then compare it
    task automatic wait_bit(input int idx, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && obs[idx] !== v; i++) @(negedge mclk);
        check({7'h00, obs[idx]}, {7'h00, v});
    endtask
    task automatic pull_out;
        inserted = 1'b0;
        step(8);
        check({1'b0, obs}, 8'h00);
    endtask

    task automatic t_plugin;
        step(5);
        check({1'b0, obs}, 8'h02);
        step(1);
        rstn = 1'b1;
        step(STEP / 2);
        check({1'b0, obs}, 8'h02);
        step(STEP);
        check({1'b0, obs}, 8'h01);
        step(STEP);
        check({1'b0, obs}, 8'h03);
        step(STEP);
        check({1'b0, obs}, 8'h00);
    endtask

    task automatic t_good;
        kind = 2'h0;
        inserted = 1'b1;
        step(SET - 8);
        check({1'b0, obs}, 8'h00);
        wait_bit(6, 1'b1, 40);
        wait_bit(2, 1'b1, OPN + SHT + 40);
        step(2);
        check({1'b0, obs}, 8'h66);
        temp[0] = 1'b1;
        wait_bit(3, 1'b1, 10);
        temp[0] = 1'b0;
        wait_bit(5, 1'b0, 200);
        wait_bit(4, 1'b1, 400);
        wait_bit(0, 1'b1, 200);
        step(2);
        check({1'b0, obs}, 8'h01);
        drain = 1'b1;
        wait_bit(6, 1'b1, 120);
        // recharge keeps the end-of-charge colour
        check({1'b0, obs}, 8'h45);
        drain = 1'b0;
        wait_bit(6, 1'b0, 400);
        check({1'b0, obs}, 8'h01);
        pull_out();
    endtask

    task automatic t_fault(input logic [1:0] k, input int lim, input logic [7:0] led);
        kind = k;
        inserted = 1'b1;
        wait_bit(6, 1'b1, SET + 40);
        wait_bit(6, 1'b0, lim);
        wait_bit(1, led[1], FL);
        check({1'b0, obs}, led);
        pull_out();
    endtask

    task automatic t_temp;
        kind = 2'h0;
        temp[3] = 1'b1;
        inserted = 1'b1;
        step(SET + OPN + 40);
        check({1'b0, obs}, 8'h00);
        pull_out();
        temp[3] = 1'b0;
        inserted = 1'b1;
        wait_bit(2, 1'b1, SET + OPN + SHT + 80);
        temp[1] = 1'b1;
        step(10);
        check({7'h00, obs[6]}, 8'h01);
        temp[2] = 1'b1;
        wait_bit(6, 1'b0, 10);
        // idle applies the lower limit, so no restart with only it set
        temp[2] = 1'b0;
        step(SET + 40);
        check({1'b0, obs}, 8'h00);
        pull_out();
        temp = 4'h0;
    endtask

    // load keeps the cell from filling, so only the timer can end the charge
    task automatic t_tout;
        kind = 2'h0;
        inserted = 1'b1;
        wait_bit(2, 1'b1, SET + OPN + SHT + 80);
        wait_bit(5, 1'b0, 200);
        drain = 1'b1;
        step(TOUT * DIV - 200);
        check({1'b0, obs}, 8'h46);
        wait_bit(0, 1'b1, 300);
        check({1'b0, obs}, 8'h01);
        drain = 1'b0;
        pull_out();
    endtask

    initial begin
        t_plugin();
        t_good();
        t_fault(2'h1, OPN + 40, 8'h00);
        t_fault(2'h2, OPN + SHT + 40, 8'h03);
        t_fault(2'h3, OPN + SHT + TOUT / 8 * DIV + 40, 8'h03);
        t_temp();
        t_tout();
        tally_and_finish();
    end
endmodule
